// ==== verilog/pas_pkg.sv ====
/*
  shared constants for the pipelined sample port: widths, latency, codes.
  assumes a single core clock at the maximum sampling rate.
*/
`default_nettype none
package pas_pkg;
  // ----------------------------------------
  // widths and pipeline shape
  // ----------------------------------------
  localparam int PAS_WORD_W = 8;
  localparam int PAS_STAGES = 8;
  localparam int PAS_LATENCY = 5;
  localparam int PAS_IN_W = 10;
  // ----------------------------------------
  // codes and input scale
  // ----------------------------------------
  localparam logic [7:0] PAS_CODE_MAX = 8'hff;
  localparam logic [7:0] PAS_CODE_MIN = 8'h00;
  localparam logic signed [9:0] PAS_IN_POS_FS = 10'sh0ff;
  localparam logic signed [9:0] PAS_IN_NEG_FS = -10'sh100;
  localparam logic [7:0] PAS_WORD_RST = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int PAS_CLK_MHZ = 20;
  localparam int PAS_MAX_SMPL_MHZ = 20;
endpackage
`default_nettype wire

// ==== verilog/pas_buf2.sv ====
/*
  two-entry buffer with valid/ready on both sides.
  assumes one clock and synchronous active-high reset.
*/
`default_nettype none
module pas_buf2 #(
  parameter int WIDTH = 9
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [WIDTH-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic [WIDTH-1:0] out_data_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_q != 2'd2);
  assign out_valid = (count_q != 2'd0);
  wire [WIDTH-1:0] head_d = (count_q == 2'd2) ? mem_q[~rd_ptr_q] : in_data;
  wire head_load = pop || (count_q == 2'd0);
  assign out_data = out_data_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'd0;
      out_data_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
      if (head_load) begin
        out_data_q <= head_d;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/pas_sample_port.sv ====
/*
  digital side of an 8-bit pipelined sampling converter: sample, quantize
  in eight stages, error-correct, present word and range flag.
  assumes the sampled input arrives as a signed two's complement level in
  core_clk domain and the receiver may stall through sample_ready.
*/
`default_nettype none
// Function
// - a low power_down_n puts the converter in shutdown and high lets it convert.
// - while the sampling clock is high the sampling stage tracks the input.
// - each falling sampling edge freezes the input and starts a conversion.
// - each sample's word appears after the fifth sample edge following its capturing edge.
// - an input above range gives range_flag high and an all-ones word.
// - an input below range gives range_flag high and an all-zeros word.
// - an in-range conversion gives range_flag low.
// - a difference of plus one volt gives the largest code.
// - a difference of minus one volt gives the smallest code.
// - the quantizer is eight stages, msb first, each passing a doubled residue.
// - stage decisions are merged by error-correction logic into the word.
// - the word is straight binary, all ones at plus and all zeros at minus full scale.
module pas_sample_port
  import pas_pkg::*;
#(
  parameter int LATENCY = PAS_LATENCY
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic power_down_n,
  input wire logic track_in,
  input wire logic signed [PAS_IN_W-1:0] analog_in,
  output logic [PAS_WORD_W-1:0] sample_word,
  output logic range_flag,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic powered_up
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pd_sync_q;
  logic [2:0] trk_sync_q;
  logic pd_n_q;
  logic trk_q;
  logic trk_prev_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pd_sync_q <= 3'b000;
      trk_sync_q <= 3'b000;
      pd_n_q <= 1'b0;
      trk_q <= 1'b0;
      trk_prev_q <= 1'b0;
    end else begin
      pd_sync_q <= {pd_sync_q[1:0], power_down_n};
      trk_sync_q <= {trk_sync_q[1:0], track_in};
      if (pd_sync_q[1] == pd_sync_q[2]) begin
        pd_n_q <= pd_sync_q[2];
      end
      if (trk_sync_q[1] == trk_sync_q[2]) begin
        trk_q <= trk_sync_q[2];
      end
      trk_prev_q <= trk_q;
    end
  end

  wire active = pd_n_q;
  wire sample_edge = active && trk_prev_q && !trk_q;
  assign powered_up = pd_n_q;

  // ----------------------------------------
  // track and hold
  // ----------------------------------------
  logic signed [PAS_IN_W-1:0] track_q;
  logic signed [PAS_IN_W-1:0] hold_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      track_q <= '0;
      hold_q <= '0;
    end else begin
      if (active && trk_q) begin
        track_q <= analog_in;
      end
      if (sample_edge) begin
        hold_q <= track_q;
      end
    end
  end

  // ----------------------------------------
  // range detect and clamp
  // ----------------------------------------
  wire over = hold_q > PAS_IN_POS_FS;
  wire under = hold_q < PAS_IN_NEG_FS;
  wire [PAS_IN_W-1:0] offset_sum = PAS_IN_W'(hold_q - PAS_IN_NEG_FS);
  wire [PAS_WORD_W-1:0] offset_code = offset_sum[PAS_WORD_W:1];

  // ----------------------------------------
  // eight-stage quantizer
  // ----------------------------------------
  localparam int RW = PAS_WORD_W + 1;
  logic [RW-1:0] res_q [PAS_STAGES];
  logic [PAS_WORD_W-1:0] bits_q [PAS_STAGES];
  logic [PAS_STAGES-1:0] of_pipe_q;
  logic [PAS_STAGES-1:0] uf_pipe_q;
  logic [PAS_STAGES-1:0] vld_pipe_q;

  function automatic logic [PAS_WORD_W-1:0] pas_correct(input logic [PAS_WORD_W-1:0] raw,
                                                         input logic ov, input logic un);
    if (ov) begin
      pas_correct = PAS_CODE_MAX;
    end else if (un) begin
      pas_correct = PAS_CODE_MIN;
    end else begin
      pas_correct = raw;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < PAS_STAGES; g++) begin : g_stage
      wire [RW-1:0] res_in;
      wire [PAS_WORD_W-1:0] bits_in;
      if (g == 0) begin : g_first
        assign res_in = {1'b0, offset_code};
        assign bits_in = '0;
      end else begin : g_next
        assign res_in = res_q[g-1];
        assign bits_in = bits_q[g-1];
      end
      wire decide = res_in[PAS_WORD_W-1];
      wire [RW-1:0] res_sub = decide ? (res_in - RW'(1 << (PAS_WORD_W - 1))) : res_in;
      always_ff @(posedge core_clk) begin
        if (rst) begin
          res_q[g] <= '0;
          bits_q[g] <= '0;
        end else begin
          res_q[g] <= RW'(res_sub << 1);
          bits_q[g] <= bits_in | (decide ? PAS_WORD_W'(1 << (PAS_WORD_W - 1 - g)) : '0);
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      of_pipe_q <= '0;
      uf_pipe_q <= '0;
      vld_pipe_q <= '0;
    end else begin
      of_pipe_q <= {of_pipe_q[PAS_STAGES-2:0], over};
      uf_pipe_q <= {uf_pipe_q[PAS_STAGES-2:0], under};
      vld_pipe_q <= {vld_pipe_q[PAS_STAGES-2:0], sample_edge};
    end
  end

  // ----------------------------------------
  // latency alignment: quantizer is PAS_STAGES deep, the word must emerge
  // LATENCY sample edges later; a chain of LATENCY word registers shifted on each sample edge aligns it
  // ----------------------------------------
  wire [PAS_WORD_W-1:0] corrected = pas_correct(bits_q[PAS_STAGES-1],
    of_pipe_q[PAS_STAGES-1], uf_pipe_q[PAS_STAGES-1]);
  wire done_flag = of_pipe_q[PAS_STAGES-1] | uf_pipe_q[PAS_STAGES-1];

  logic [PAS_WORD_W:0] lat_q [LATENCY];
  logic [PAS_WORD_W:0] conv_q;
  logic conv_take_q;

  // last stage holds the new word one cycle after its tag leaves the pipe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_q <= '0;
      conv_take_q <= 1'b0;
    end else begin
      conv_take_q <= vld_pipe_q[PAS_STAGES-1];
      if (conv_take_q) begin
        conv_q <= {done_flag, corrected};
      end
    end
  end

  generate
    for (g = 0; g < LATENCY; g++) begin : g_lat
      wire [PAS_WORD_W:0] lat_in;
      if (g == 0) begin : g_head
        assign lat_in = conv_q;
      end else begin : g_tail
        assign lat_in = lat_q[g-1];
      end
      always_ff @(posedge core_clk) begin
        if (rst) begin
          lat_q[g] <= '0;
        end else if (sample_edge) begin
          lat_q[g] <= lat_in;
        end
      end
    end
  endgenerate

  logic [3:0] edge_cnt_q;
  always_ff @(posedge core_clk) begin
    if (rst || !active) begin
      edge_cnt_q <= 4'h0;
    end else if (sample_edge && edge_cnt_q != 4'hf) begin
      edge_cnt_q <= edge_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  wire buf_in_ready;
  wire [PAS_WORD_W:0] buf_out;
  logic push_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      push_q <= 1'b0;
    end else begin
      push_q <= sample_edge;
    end
  end

  pas_buf2 #(.WIDTH(PAS_WORD_W + 1)) u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push_q && active),
    .in_ready(buf_in_ready),
    .in_data(lat_q[LATENCY-1]),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data(buf_out)
  );

  assign sample_word = buf_out[PAS_WORD_W-1:0];
  assign range_flag = buf_out[PAS_WORD_W];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_over_code;
    @(posedge core_clk) disable iff (rst)
      (conv_take_q && of_pipe_q[PAS_STAGES-1]) |=> (conv_q == {1'b1, PAS_CODE_MAX});
  endproperty
  a_over_code: assert property (p_over_code) else $error("overrange code wrong");

  property p_under_code;
    @(posedge core_clk) disable iff (rst)
      (conv_take_q && uf_pipe_q[PAS_STAGES-1]) |=> (conv_q == {1'b1, PAS_CODE_MIN});
  endproperty
  a_under_code: assert property (p_under_code) else $error("underrange code wrong");

  property p_in_range;
    @(posedge core_clk) disable iff (rst)
      (conv_take_q && !done_flag) |=> !conv_q[PAS_WORD_W];
  endproperty
  a_in_range: assert property (p_in_range) else $error("flag set in range");

  property p_quant;
    @(posedge core_clk) disable iff (rst)
      sample_edge ##1 1 |-> ##(PAS_STAGES) (bits_q[PAS_STAGES-1] == $past(offset_code, 8));
  endproperty
  a_quant: assert property (p_quant) else $error("quantizer mismatch");

  property p_full_pos;
    @(posedge core_clk) disable iff (rst)
      (hold_q == PAS_IN_POS_FS) |-> (offset_code == PAS_CODE_MAX);
  endproperty
  a_full_pos: assert property (p_full_pos) else $error("positive full scale code");

  property p_full_neg;
    @(posedge core_clk) disable iff (rst)
      (hold_q == PAS_IN_NEG_FS) |-> (offset_code == PAS_CODE_MIN);
  endproperty
  a_full_neg: assert property (p_full_neg) else $error("negative full scale code");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
      !sample_edge |=> $stable(hold_q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold changed off edge");

  property p_shutdown;
    @(posedge core_clk) disable iff (rst)
      !pd_n_q |=> !push_q && $stable(track_q);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("activity in shutdown");

  property p_track;
    @(posedge core_clk) disable iff (rst)
      (active && trk_q) |=> (track_q == $past(analog_in));
  endproperty
  a_track: assert property (p_track) else $error("track stage not following input");

  property p_word_per_edge;
    @(posedge core_clk) disable iff (rst)
      sample_edge |=> push_q;
  endproperty
  a_word_per_edge: assert property (p_word_per_edge) else $error("sample edge gave no word");

  property p_push_seen;
    @(posedge core_clk) disable iff (rst)
      (push_q && active && buf_in_ready) |=> sample_valid;
  endproperty
  a_push_seen: assert property (p_push_seen) else $error("pushed word not offered");

  property p_no_early_push;
    @(posedge core_clk) disable iff (rst)
      (edge_cnt_q == 4'h0) |-> !push_q;
  endproperty
  a_no_early_push: assert property (p_no_early_push) else $error("word before first edge");
endmodule
`default_nettype wire

// ==== verification/pas_capture_model.sv ====
/*
  capture-side model: makes the converter clock and the receiver ready.
  assumes core_clk at 20 MHz and a synchronous active-high rst.
*/
`default_nettype none
module pas_capture_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic stall,
  output logic track_in,
  output logic sample_ready,
  output logic start
);
  // ----------------------------------------
  // converter clock, 16 core cycles a period
  // ----------------------------------------
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // half high, still low while idle
  assign track_in = run && !cnt_q[3];
  assign start = run && (cnt_q == 4'h0);
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign sample_ready = !stall;
endmodule
`default_nettype wire

// ==== verification/pas_sample_port_test.sv ====
/*
  self-checking bench for the sample port: codes, latency, stall, shutdown.
  assumes pas_pkg, pas_sample_port and pas_capture_model are compiled first.
*/
`default_nettype none
module pas_sample_port_test
  import pas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst, power_down_n, run, stall, track_in, sample_ready, start;
  logic signed [PAS_IN_W-1:0] analog_in;
  logic [PAS_WORD_W-1:0] sample_word;
  logic range_flag, sample_valid, powered_up;
  int n_mismatch, comparisons, i;
  logic [8:0] got[$];
  typedef struct {logic signed [9:0] lvl; logic [8:0] exp;} pas_row_type;
  pas_row_type rows[10] = '{'{10'sh0ff, 9'h0ff}, '{-10'sh100, 9'h000},
    '{10'sh000, 9'h080}, '{-10'sh002, 9'h07f}, '{10'sh064, 9'h0b2},
    '{-10'sh0c8, 9'h01c}, '{10'sh100, 9'h1ff}, '{10'sh1ff, 9'h1ff},
    '{-10'sh101, 9'h100}, '{10'sh200, 9'h100}};

  pas_sample_port #(.LATENCY(PAS_LATENCY)) uut (.core_clk(core_clk), .rst(rst),
    .power_down_n(power_down_n), .track_in(track_in), .analog_in(analog_in),
    .sample_word(sample_word), .range_flag(range_flag), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .powered_up(powered_up));
  pas_capture_model cap (.core_clk(core_clk), .rst(rst), .run(run), .stall(stall),
    .track_in(track_in), .sample_ready(sample_ready), .start(start));

  // ----------------------------------------
  // clock, monitor, tasks
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (rst === 1'b0 && sample_valid === 1'b1 && sample_ready === 1'b1) begin
      got.push_back({range_flag, sample_word});
    end
  end
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic period(input logic signed [9:0] lvl);
    do @(posedge core_clk); while (start !== 1'b1);
    analog_in <= lvl;
  endtask
  task automatic finish_run();
    repeat (14) @(posedge core_clk);
    run <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic wait_up(input logic lvl);
    for (int k = 0; k < 10 && powered_up !== lvl; k++) @(posedge core_clk);
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    results();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    power_down_n = 1'b1;
    analog_in = '0;
    run = 1'b0;
    stall = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check("reset word", {range_flag, sample_word}, 9'h000);
    check("reset valid", {8'h00, sample_valid}, 9'h000);
    wait_up(1'b1);
    check("powered", {8'h00, powered_up}, 9'h001);
    run <= 1'b1;
    for (i = 0; i < 15; i++) begin
      period(i < 10 ? rows[i].lvl : 10'sh000);
      if (i == 4) stall <= 1'b1;
      if (i == 6) begin
        check("stall valid", {8'h00, sample_valid}, 9'h001);
        stall <= 1'b0;
      end
    end
    finish_run();
    check("word count", 9'(got.size()), 9'd15);
    for (i = 0; i < 10; i++) begin
      check("row word", got[i + 5], rows[i].exp);
    end
    got.delete();
    power_down_n <= 1'b0;
    wait_up(1'b0);
    check("shutdown", {8'h00, powered_up}, 9'h000);
    run <= 1'b1;
    repeat (4) period(10'sh064);
    finish_run();
    check("shutdown words", 9'(got.size()), 9'd0);
    power_down_n <= 1'b1;
    wait_up(1'b1);
    run <= 1'b1;
    repeat (7) period(10'sh064);
    finish_run();
    check("wake count", 9'(got.size()), 9'd7);
    // first five words after wake are stale and skipped
    check("wake word", got[5], 9'h0b2);
    check("wake word", got[6], 9'h0b2);
    results();
  end
endmodule
`default_nettype wire
